// >>> bench/conv_core_model.sv
// Behavioural analog core answering a start with a done pulse unless power drops or a new start re-arms it first.
`timescale 1ns/100ps
module conv_core_model #(
  parameter int CONV_CYC = 10
) (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       start_i,
  input  wire       sample_i,
  input  wire       power_i,
  input  wire [9:0] value_i,
  output logic      done_o,
  output wire [9:0] result_o
);
  logic       armed_q;
  logic       seen_q;
  int         cnt_q;
  logic [9:0] val_q;
  // Outside done the result shows the inverse, so stale captures cannot pass.
  assign result_o = done_o ? val_q : ~val_q;
  // Runs on the bus clock itself; losing power aborts the cycle like the real core.
  always @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    if (!nrst_i || !power_i) begin
      armed_q <= 1'b0;
    end else if (start_i) begin
      armed_q <= 1'b1;
      seen_q <= 1'b0;
      cnt_q <= 0;
    end else if (armed_q) begin
      if (sample_i) seen_q <= 1'b1;
      else if (seen_q) cnt_q <= cnt_q + 1;
      if (cnt_q == CONV_CYC) begin
        done_o <= 1'b1;
        armed_q <= 1'b0;
        val_q <= value_i;
      end
    end
  end
endmodule

// >>> bench/conv_ctrl_monitor.sv
// Port checker for the converter control block.
`timescale 1ns/100ps
module conv_ctrl_monitor (
  input wire       ref_clk_i,
  input wire       nrst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire       break_i,
  input wire       core_done_i,
  input wire       core_start_o,
  input wire [4:0] core_channel_o,
  input wire       pad_connect_o,
  input wire       irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [2:0] brk_q;
  // Break passes two flops inside, so clears are judged only after it has been low a while.
  always @(posedge ref_clk_i) brk_q <= {brk_q[1:0], break_i};
  wire quiet = !break_i && brk_q == 3'h0;
  wire sc_wr = wr_i && addr_i == 3'h0;
  property p_start; sc_wr && wdata_i[4:0] != 5'h1F |=> core_start_o; endproperty
  a_start: assert property (p_start) else $error("no start after write");
  property p_off; sc_wr && wdata_i[4:0] == 5'h1F |=> !core_start_o [*4]; endproperty
  a_off: assert property (p_off) else $error("start with channel off");
  property p_chan; sc_wr |=> core_channel_o == $past(wdata_i[4:0]); endproperty
  a_chan: assert property (p_chan) else $error("channel not taken");
  property p_pad; sc_wr |=> pad_connect_o == ($past(wdata_i[4:0]) <= 5'h07); endproperty
  a_pad: assert property (p_pad) else $error("pad connect wrong");
  // Completion reaches the flags one cycle after the core's done, and then wins a clear.
  property p_irq_wr; sc_wr && quiet && !$past(core_done_i) |=> !irq_o; endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("irq kept after write");
  property p_irq_rd;
    rd_i && addr_i == 3'h2 && quiet && !$past(core_done_i) |=> !irq_o;
  endproperty
  a_irq_rd: assert property (p_irq_rd) else $error("irq kept after read");
  property p_irq_cause; $rose(irq_o) |-> $past(core_done_i, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
  property p_reset; $rose(nrst_i) |-> !irq_o && !core_start_o; endproperty
  a_reset: assert property (p_reset) else $error("busy out of reset");
  c_done: cover property (core_done_i);
  c_irq: cover property ($rose(irq_o));
  c_cont: cover property (sc_wr && wdata_i[5]);
endmodule
bind conv_ctrl conv_ctrl_monitor u_conv_ctrl_monitor (.ref_clk_i, .nrst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .break_i, .core_done_i, .core_start_o, .core_channel_o, .pad_connect_o, .irq_o);

// >>> bench/conv_ctrl_tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module conv_ctrl_tb_top;
  logic ref_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, brk = 1'b0, stop = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [9:0] value = 10'h000;
  wire  [7:0] rdata;
  wire  [9:0] result;
  wire        done, start, sample, power, irq, clk_sel, arun;
  int err_count = 0, check_count = 0, start_n = 0, done_n = 0, cyc = 0, s, n;
  int smp_n = 0;
  always #50 ref_clk = ~ref_clk;
  conv_ctrl u_conv_ctrl (.ref_clk_i(ref_clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .break_i(brk), .stop_mode_i(stop),
    .core_done_i(done), .core_result_i(result), .core_start_o(start), .core_sample_o(sample),
    .core_power_o(power), .core_channel_o(), .pad_connect_o(), .clk_select_o(clk_sel),
    .async_clk_run_o(arun), .irq_o(irq));
  conv_core_model u_conv_core_model (.ref_clk_i(ref_clk), .nrst_i(nrst), .start_i(start),
    .sample_i(sample), .power_i(power), .value_i(value), .done_o(done), .result_o(result));
  // Counts starts and completions, and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (start) start_n <= start_n + 1;
    if (done) done_n <= done_n + 1;
    if (sample) smp_n <= smp_n + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are checked there.
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wait_done(input int k);
    for (int i = 0; i < 500 && done_n < k; i++) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    chk(done_n >= k, 1'b1);
  endtask
  task automatic conv(input logic [7:0] d);
    n = done_n;
    wr_reg(3'h0, d);
    wait_done(n + 1);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_single;
    s = start_n;
    value <= 10'h2B6;
    conv(8'h43);
    chk(irq, 1'b1);
    chk(power, 1'b0);
    rd_reg(3'h0, 8'hC3);
    rd_reg(3'h2, 8'hAD);
    rd_reg(3'h0, 8'h43);
    chk(irq, 1'b0);
    chk(start_n - s, 1);
    $display("single end");
  endtask
  task automatic t_cont;
    n = done_n;
    s = start_n;
    value <= 10'h3FC;
    wr_reg(3'h0, 8'h25);
    wait_done(n + 2);
    rd_reg(3'h2, 8'hFF);
    chk(start_n - s > 2, 1'b1);
    wr_reg(3'h0, 8'h1F);
    #1;
    s = start_n;
    n = done_n;
    idle(60);
    chk(start_n - s + done_n - n, 0);
    rd_reg(3'h0, 8'h1F);
    $display("continuous end");
  endtask
  task automatic t_abort;
    s = start_n;
    n = done_n;
    wr_reg(3'h0, 8'h02);
    idle(3);
    wr_reg(3'h0, 8'h02);
    idle(80);
    chk(start_n - s, 2);
    chk(done_n - n, 1);
    $display("abort end");
  endtask
  // A flag must survive a low-result read made during break while clearing is off.
  task automatic t_break;
    value <= 10'h0F0;
    conv(8'h01);
    brk <= 1'b1;
    idle(4);
    rd_reg(3'h2, 8'h3C);
    rd_reg(3'h0, 8'h81);
    brk <= 1'b0;
    idle(4);
    rd_reg(3'h0, 8'h81);
    rd_reg(3'h2, 8'h3C);
    rd_reg(3'h0, 8'h01);
    wr_reg(3'h4, 8'h01);
    rd_reg(3'h4, 8'h01);
    conv(8'h01);
    brk <= 1'b1;
    idle(4);
    rd_reg(3'h2, 8'h3C);
    brk <= 1'b0;
    idle(4);
    rd_reg(3'h0, 8'h01);
    wr_reg(3'h4, 8'h00);
    $display("break end");
  endtask
  task automatic t_stop;
    n = done_n;
    wr_reg(3'h0, 8'h24);
    wait_done(n + 1);
    stop <= 1'b1;
    idle(6);
    stop <= 1'b0;
    idle(4);
    s = start_n;
    idle(60);
    chk(start_n - s, 0);
    conv(8'h24);
    wr_reg(3'h3, 8'h00);
    #1;
    s = start_n;
    idle(60);
    chk(start_n - s, 0);
    wr_reg(3'h0, 8'h1F);
    // Leave the off state standing a few cycles before the next start.
    idle(4);
    $display("stop end");
  endtask
  // Async clock on: stop entry must not end the conversion; long sample on divide by 8.
  task automatic t_async;
    n = done_n;
    wr_reg(3'h3, 8'hF1);
    chk(clk_sel, 1'b1);
    s = smp_n;
    wr_reg(3'h0, 8'h02);
    idle(3);
    chk(arun, 1'b1);
    stop <= 1'b1;
    idle(6);
    stop <= 1'b0;
    wait_done(n + 1);
    chk(smp_n - s >= 184 && smp_n - s <= 200, 1'b1);
    chk(arun, 1'b0);
    chk(power, 1'b0);
    wr_reg(3'h3, 8'h00);
    $display("async end");
  endtask
  task automatic t_wide;
    wr_reg(3'h3, 8'h04);
    value <= 10'h2B6;
    conv(8'h03);
    rd_reg(3'h1, 8'h02);
    value <= 10'h111;
    conv(8'h03);
    rd_reg(3'h2, 8'hB6);
    rd_reg(3'h7, 8'h00);
    wr_reg(3'h3, 8'h00);
    $display("wide end");
  endtask
  // Reset, then each scenario in turn.
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    idle(1);
    rd_reg(3'h0, 8'h1F);
    chk(irq, 1'b0);
    t_single();
    t_cont();
    t_abort();
    t_break();
    t_stop();
    t_async();
    t_wide();
    final_report();
  end
endmodule

// >>> rtl/conv_clock_div.v
// Conversion clock enable generator: one pulse every 1, 2, 4 or 8 input clocks.
`timescale 1ns/100ps
module conv_clock_div (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire [1:0] div_sel_i,
  input  wire       run_i,
  output reg        tick_o
);
  reg  [2:0] cnt_q;
  wire [2:0] limit;

  // Divider limit is the divide ratio minus one.
  assign limit = (3'h1 << div_sel_i) - 3'h1;

  // The counter rests while idle so every conversion starts phase aligned.
  always @(posedge ref_clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt_q  <= 3'h0;
      tick_o <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= 3'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 3'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// >>> rtl/conv_ctrl.v
// Converter control: registers, start and stop logic, result capture and flags.
// Register map, by index on addr_i:
//   0 status and control: bit 7 done (read only), 6 irq enable, 5 continuous, 4:0 channel.
//   1 result high: the two upper result bits in 10-bit mode, zero in 8-bit mode.
//   2 result low: result bits 7:0 in 10-bit mode, bits 9:2 in 8-bit mode.
//   3 clock config: 7 async enable, 6:5 divider, 4 long sample, 3:2 mode, 0 input clock.
//   4 break control: bit 0 lets software clear status bits during a break.
//   5 status: 0 busy, 1 continuous active, 2 halted by stop entry.
// Unmapped reads return zero and unmapped writes are dropped.
//
// Timing, counted from the edge that takes a control write:
//   that same edge aborts the sequencer, loads the channel and arms the start strobe;
//   the start strobe and the new channel stand in the cycle after the write;
//   the sample phase follows one cycle later, while core power rises with the start strobe;
//   the done pulse of the core is followed two edges later by the flag and result update.
// Read data stand in the single cycle after the read strobe and are zero otherwise.
//
// Limitations:
//   The sample phase is counted in whole conversion ticks, so the trailing half cycle
//   is rounded up to the next tick.
//   A clock register write in the cycle after a control write drops that conversion,
//   since its abort reaches the sequencer together with the start strobe.
//   The conversion phase ends on the done of the core only; there is no timer here
//   that would catch a core that never answers.
//   Break and stop come from other clock regions and pass two flops, so they take
//   effect two reference clocks after the pin changes.
`timescale 1ns/100ps
`include "conv_ctrl_defines.vh"
module conv_ctrl (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       break_i,
  input  wire       stop_mode_i,
  input  wire       core_done_i,
  input  wire [9:0] core_result_i,
  output wire       core_start_o,
  output wire       core_sample_o,
  output wire       core_power_o,
  output reg  [4:0] core_channel_o,
  output reg        pad_connect_o,
  output wire       clk_select_o,
  output wire       async_clk_run_o,
  output wire       irq_o
);
  reg  [7:0] sc_q;
  reg  [7:0] clk_cfg_q;
  reg        break_clear_enable_q;
  reg        done_q;
  reg        irq_q;
  reg        cont_q;
  reg        hold_q;
  reg        stop_halt_q;
  reg  [9:0] result_q;
  reg  [9:0] core_res_q;
  wire [4:0] ch_next;
  reg        brk_s1_q;
  reg        brk_s2_q;
  reg        stp_s1_q;
  reg        stp_s2_q;
  reg        stp_prev_q;
  reg        start_q;
  wire       busy;
  wire       seq_done;
  wire       tick;
  wire       sc_wr;
  wire       clk_wr;
  wire       rd_low;
  wire       rd_high;
  wire       stop_entry;
  wire       abort;
  wire       flag_clr_ok;
  wire       mode10;
  wire       async_en;

  // Channel all ones means converter off.
  function ch_is_off;
    input [4:0] ch;
    begin
      ch_is_off = (ch == `CH_OFF);
    end
  endfunction

  // Reserved codes give an undefined result; the core is simply asked anyway.
  function ch_is_pad;
    input [4:0] ch;
    begin
      ch_is_pad = (ch <= `CH_PORT_B_LAST);
    end
  endfunction

  assign sc_wr    = wr_i && (addr_i == `ADDR_SC);
  assign clk_wr   = wr_i && (addr_i == `ADDR_CLK_CFG);
  assign rd_low   = rd_i && (addr_i == `ADDR_RES_LOW);
  assign rd_high  = rd_i && (addr_i == `ADDR_RES_HIGH);
  assign mode10   = (clk_cfg_q[`CLK_MODE_LSB+1:`CLK_MODE_LSB] == `MODE_10BIT);
  assign async_en = clk_cfg_q[`CLK_ASYNC_CLOCK_ENABLE_BIT];

  // Break and stop requests come from other logic on pins, so they are synchronised.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      brk_s1_q   <= 1'b0;
      brk_s2_q   <= 1'b0;
      stp_s1_q   <= 1'b0;
      stp_s2_q   <= 1'b0;
      stp_prev_q <= 1'b0;
    end else begin
      brk_s1_q   <= break_i;
      brk_s2_q   <= brk_s1_q;
      stp_s1_q   <= stop_mode_i;
      stp_s2_q   <= stp_s1_q;
      stp_prev_q <= stp_s2_q;
    end
  end

  // Stop entry ends conversions only while the async clock is off.
  assign stop_entry  = stp_s2_q && !stp_prev_q && !async_en;
  // Status bits may only be cleared outside break, or in break when allowed.
  assign flag_clr_ok = !brk_s2_q || break_clear_enable_q;
  // Writes to the control or clock register, or stop entry, halt all activity.
  assign abort = sc_wr || clk_wr || stop_entry;

  // Register storage; the done bit inside sc_q is not stored, it reads from done_q.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sc_q      <= `SC_RESET;
      clk_cfg_q <= `CLK_RESET;
      break_clear_enable_q    <= 1'b0;
    end else begin
      if (sc_wr) begin
        sc_q <= {1'b0, wdata_i[6:0]};
      end
      if (clk_wr) begin
        clk_cfg_q <= wdata_i;
      end
      if (wr_i && (addr_i == `ADDR_BREAK_CTRL)) begin
        break_clear_enable_q <= wdata_i[0];
      end
    end
  end

  // Start decision: every control write with a live channel starts one conversion.
  // Continuous mode restarts after each completion; stop halt waits for a new write.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      start_q     <= 1'b0;
      cont_q      <= 1'b0;
      stop_halt_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (sc_wr) begin
        stop_halt_q <= 1'b0;
        cont_q  <= wdata_i[`SC_CONT_BIT] && !ch_is_off(wdata_i[4:0]);
        start_q <= !ch_is_off(wdata_i[4:0]);
      end else if (clk_wr) begin
        cont_q <= 1'b0;
      end else if (stop_entry) begin
        cont_q      <= 1'b0;
        stop_halt_q <= 1'b1;
      end else if (seq_done && cont_q && !stop_halt_q) begin
        start_q <= 1'b1;
      end
    end
  end

  assign core_start_o = start_q;
  // Powered only while converting, so low power returns by itself at the end.
  assign core_power_o = busy || start_q;

  // The channel takes the written value at once, so it stands beside the start strobe.
  assign ch_next = sc_wr ? wdata_i[4:0] : sc_q[4:0];

  // Channel and pad isolation; the core must never start on the previous channel.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      core_channel_o <= `CH_OFF;
      pad_connect_o  <= 1'b0;
    end else begin
      core_channel_o <= ch_next;
      pad_connect_o  <= ch_is_pad(ch_next) && !ch_is_off(ch_next);
    end
  end

  // Result capture with the high/low read interlock of 10-bit mode.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      result_q   <= 10'h000;
      core_res_q <= 10'h000;
      hold_q     <= 1'b0;
    end else begin
      // The core shows its word only in its done cycle, one cycle before the sequencer
      // reports completion, so the word is caught here first.
      if (core_done_i) begin
        core_res_q <= core_result_i;
      end
      if (seq_done && !hold_q) begin
        result_q <= core_res_q;
      end
      if (rd_high && mode10) begin
        hold_q <= 1'b1;
      end else if (rd_low || !mode10) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Done flag and interrupt: a completion in the clearing cycle wins.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      done_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      if (seq_done) begin
        done_q <= 1'b1;
      end else if ((sc_wr || rd_low) && flag_clr_ok) begin
        done_q <= 1'b0;
      end
      if (seq_done && sc_q[`SC_IRQ_EN_BIT]) begin
        irq_q <= 1'b1;
      end else if ((sc_wr || rd_low || rd_high) && flag_clr_ok) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign irq_o           = irq_q;
  assign clk_select_o    = clk_cfg_q[`CLK_ICLK_BIT];
  assign async_clk_run_o = async_en && busy;

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_SC:         rdata_o <= {done_q, sc_q[6:0]};
        `ADDR_RES_HIGH:   rdata_o <= mode10 ? {6'h00, result_q[9:8]} : 8'h00;
        `ADDR_RES_LOW:    rdata_o <= mode10 ? result_q[7:0] : result_q[9:2];
        `ADDR_CLK_CFG:    rdata_o <= clk_cfg_q;
        `ADDR_BREAK_CTRL: rdata_o <= {7'h00, break_clear_enable_q};
        `ADDR_STATUS:     rdata_o <= {5'h00, stop_halt_q, cont_q, busy};
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  conv_clock_div u_div (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .div_sel_i (clk_cfg_q[6:5]),
    .run_i     (busy),
    .tick_o    (tick)
  );

  conv_sequencer u_seq (
    .ref_clk_i     (ref_clk_i),
    .nrst_i        (nrst_i),
    .start_i       (start_q),
    .abort_i       (abort),
    .tick_i        (tick),
    .long_sample_i (clk_cfg_q[`CLK_LSMP_BIT]),
    .core_done_i   (core_done_i),
    .core_sample_o (core_sample_o),
    .busy_o        (busy),
    .done_o        (seq_done)
  );
endmodule

// >>> rtl/conv_ctrl_defines.vh
// Constants for the converter control block: register map, fields and timing.
`ifndef CONV_CTRL_DEFINES_VH
`define CONV_CTRL_DEFINES_VH
`define ADDR_SC          3'h0
`define ADDR_RES_HIGH    3'h1
`define ADDR_RES_LOW     3'h2
`define ADDR_CLK_CFG     3'h3
`define ADDR_BREAK_CTRL  3'h4
`define ADDR_STATUS      3'h5
`define SC_DONE_BIT      7
`define SC_IRQ_EN_BIT    6
`define SC_CONT_BIT      5
`define CH_OFF           5'h1F
`define CH_VREF_HIGH     5'h1D
`define CH_VREF_LOW      5'h1E
`define CH_PORT_B_LAST   5'h07
`define SC_RESET         8'h1F
`define CLK_RESET        8'h00
`define CLK_LSMP_BIT     4
`define CLK_MODE_LSB     2
`define CLK_ICLK_BIT     0
`define CLK_ASYNC_CLOCK_ENABLE_BIT   7
`define MODE_10BIT       2'h1
`define SHORT_SAMPLE_HALF 8'h07
`define LONG_SAMPLE_HALF  8'h2F
`define CONVERT_CYCLES   8'h0A
`endif

// >>> rtl/conv_sequencer.v
// Conversion sequencer: sample phase counted in half ticks, then conversion phase ended by the core's done.
`timescale 1ns/100ps
`include "conv_ctrl_defines.vh"
module conv_sequencer (
  input  wire ref_clk_i,
  input  wire nrst_i,
  input  wire start_i,
  input  wire abort_i,
  input  wire tick_i,
  input  wire long_sample_i,
  input  wire core_done_i,
  output reg  core_sample_o,
  output reg  busy_o,
  output reg  done_o
);
  localparam S_IDLE = 2'h0;
  localparam S_SAMP = 2'h1;
  localparam S_CONV = 2'h2;
  reg [1:0] state_q;
  reg [7:0] cnt_q;

  // Sample length is 3.5 or 23.5 conversion clocks; counted as half-cycle units.
  always @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    if (!nrst_i || abort_i) begin
      state_q       <= S_IDLE;
      cnt_q         <= 8'h00;
      core_sample_o <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (start_i) begin
            state_q       <= S_SAMP;
            busy_o        <= 1'b1;
            core_sample_o <= 1'b1;
            cnt_q <= long_sample_i ? `LONG_SAMPLE_HALF : `SHORT_SAMPLE_HALF;
          end
        end
        S_SAMP: begin
          if (tick_i) begin
            if (cnt_q <= 8'h02) begin
              state_q       <= S_CONV;
              core_sample_o <= 1'b0;
              cnt_q         <= `CONVERT_CYCLES;
            end else begin
              cnt_q <= cnt_q - 8'h02;
            end
          end
        end
        S_CONV: begin
          if (core_done_i) begin
            state_q <= S_IDLE;
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
